// ---- hdl/ppr_port_pins.v ----
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "ppr_consts.vh"
// Behaviour
// [RULE1] Port P direction bit 1 makes the pin an output, 0 an input.
// [RULE2] An enabled pulse channel forces its port P pin to output, bit unchanged, except pin 1 once the lock of RULE3 is set.
// [RULE3] First clearing of the nonmaskable mask forces port P pin 1 input forever.
// [RULE4] Drive reduce register: bits 2,1 writable, 7..3 read zero, reset zero, anytime.
// [RULE5] Serial pin 3: clock out, MOSI, second transmit, pulse five, trigger one, GPIO.
// [RULE6] Serial pin 2: timer clock, MISO, second receive, pulse four, trigger zero, GPIO.
// [RULE7] Serial pin 1: second transmit, phy data bit, first transmit, then GPIO.
// [RULE8] Serial pin 0 input goes to second receiver, else first receiver, else GPIO.
// [RULE9] Serial pins 5,4 are slave select and serial clock when claimed, else GPIO.
// [RULE10] After reset all serial pins are GPIO inputs with no function enabled.
module ppr_port_pins (
  // Clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // Avalon-MM slave
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  // Processor mask state and pulse channel enables
  input wire nmi_mask_in,
  input wire [1:0] pwm_chan_en_in,
  // Port P pins
  input wire [1:0] port_p_pin_in,
  output reg [1:0] port_p_oe_out,
  output reg [1:0] port_p_drive_reduce_out,
  output reg [1:0] nonmaskable_irq_input_out,
  // Serial group peripheral enables
  input wire free_running_clock_out_en_in,
  input wire api_clk_en_in,
  input wire spi_en_in,
  input wire spi_master_in,
  input wire sci1_en_in,
  input wire sci0_en_in,
  input wire pulse_channel_five_en_in,
  input wire pulse_channel_four_en_in,
  input wire trig1_en_in,
  input wire trig0_en_in,
  input wire phy_en_in,
  // Serial group peripheral outputs
  input wire free_running_clock_out_in,
  input wire periodic_timer_clock_out_in,
  input wire spi_mosi_in,
  input wire spi_miso_in,
  input wire spi_ss_in,
  input wire spi_sck_in,
  input wire second_serial_transmit_in,
  input wire first_serial_transmit_in,
  input wire pulse_channel_five_in,
  input wire pulse_channel_four_in,
  input wire phy_register_data_bit_in,
  // Serial group pins
  input wire [5:0] serial_pin_in,
  output reg [5:0] serial_pin_out,
  output reg [5:0] serial_pin_oe_out,
  // Routed inputs to peripherals
  output reg second_serial_receive_out,
  output reg first_serial_receive_out,
  output reg converter_trigger_one_out,
  output reg converter_trigger_zero_out,
  output reg [5:0] spi_pin_rx_out,
  output reg [5:0] serial_group_gpio_in_out
);
  // ----------------------------------------------------------------
  // Registers and synchronisers.
  // ----------------------------------------------------------------
  reg [1:0] port_p_direction_bits_reg;
  reg [1:0] port_p_drive_reduce_reg;
  reg [5:0] serial_group_gpio_bits_reg;
  reg [5:0] serial_dir_reg;
  reg nmi_locked_reg;
  reg nmi_mask_seen_reg;
  reg ack_reg;
  wire [5:0] spin_s;
  wire [1:0] ppin_s;
  wire req = (avs_read_in | avs_write_in) & ~ack_reg;
  wire wr = avs_write_in & ~ack_reg & avs_byteenable_in[0];

  ppr_sync #(.W(8)) u_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .d_in({port_p_pin_in, serial_pin_in}),
    .q_out({ppin_s, spin_s})
  );

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer with waitrequest low.
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_reg <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= `PPR_UNMAPPED_DATA;
      port_p_direction_bits_reg <= 2'b00;
      port_p_drive_reduce_reg <= 2'b00; // [RULE4]
      serial_group_gpio_bits_reg <= 6'b00_0000;
      serial_dir_reg <= 6'b00_0000; // [RULE10]
    end else begin
      ack_reg <= req;
      avs_waitrequest_out <= ~req;
      if (wr) begin
        case (avs_address_in)
          `PPR_OFF_DIR: port_p_direction_bits_reg <= avs_writedata_in[1:0];
          `PPR_OFF_DRIVE: port_p_drive_reduce_reg <= avs_writedata_in[2:1]; // [RULE4]
          `PPR_OFF_SGPIO: serial_group_gpio_bits_reg <= avs_writedata_in[5:0];
          `PPR_OFF_SDIR: serial_dir_reg <= avs_writedata_in[5:0];
          default: begin
          end
        endcase
      end
      if (avs_read_in & ~ack_reg) begin
        case (avs_address_in)
          `PPR_OFF_DIR: avs_readdata_out <= {24'h00_0000, 6'b00_0000, port_p_direction_bits_reg};
          `PPR_OFF_DRIVE: avs_readdata_out <= {24'h00_0000, 5'b0_0000, port_p_drive_reduce_reg, 1'b0}; // [RULE4]
          `PPR_OFF_SGPIO: avs_readdata_out <= {24'h00_0000, 2'b00, spin_s};
          `PPR_OFF_SDIR: avs_readdata_out <= {24'h00_0000, 2'b00, serial_dir_reg};
          default: avs_readdata_out <= `PPR_UNMAPPED_DATA;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Nonmaskable pin lock. The lock never releases short of reset, so a
  // later masking by software cannot turn the pin back into an output.
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nmi_mask_seen_reg <= 1'b1;
      nmi_locked_reg <= 1'b0;
    end else begin
      nmi_mask_seen_reg <= nmi_mask_in;
      if (nmi_mask_seen_reg & ~nmi_mask_in) begin
        nmi_locked_reg <= 1'b1; // [RULE3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin routing, registered onto the outputs.
  // ----------------------------------------------------------------
  reg [5:0] so_next;
  reg [5:0] soe_next;
  reg [1:0] poe_next;
  always @* begin
    poe_next = port_p_direction_bits_reg | pwm_chan_en_in; // [RULE1] [RULE2]
    if (nmi_locked_reg) begin
      poe_next[`PPR_NMI_PIN] = 1'b0; // [RULE3]
    end
    so_next = serial_group_gpio_bits_reg;
    soe_next = serial_dir_reg;
    // Pin 5 and 4.
    if (spi_en_in) begin
      so_next[5] = spi_ss_in; // [RULE9]
      soe_next[5] = spi_master_in;
      so_next[4] = spi_sck_in;
      soe_next[4] = spi_master_in;
    end
    // Pin 3.
    if (free_running_clock_out_en_in) begin
      so_next[3] = free_running_clock_out_in; // [RULE5]
      soe_next[3] = 1'b1;
    end else if (spi_en_in) begin
      so_next[3] = spi_mosi_in;
      soe_next[3] = spi_master_in;
    end else if (sci1_en_in) begin
      so_next[3] = second_serial_transmit_in;
      soe_next[3] = 1'b1;
    end else if (pulse_channel_five_en_in) begin
      so_next[3] = pulse_channel_five_in;
      soe_next[3] = 1'b1;
    end else if (trig1_en_in) begin
      soe_next[3] = 1'b0;
    end
    // Pin 2.
    if (api_clk_en_in) begin
      so_next[2] = periodic_timer_clock_out_in; // [RULE6]
      soe_next[2] = 1'b1;
    end else if (spi_en_in) begin
      so_next[2] = spi_miso_in;
      soe_next[2] = ~spi_master_in;
    end else if (sci1_en_in) begin
      soe_next[2] = 1'b0;
    end else if (pulse_channel_four_en_in) begin
      so_next[2] = pulse_channel_four_in;
      soe_next[2] = 1'b1;
    end else if (trig0_en_in) begin
      soe_next[2] = 1'b0;
    end
    // Pin 1 and 0.
    if (sci1_en_in) begin
      so_next[1] = second_serial_transmit_in; // [RULE7]
      soe_next[1] = 1'b1;
    end else if (phy_en_in) begin
      so_next[1] = phy_register_data_bit_in;
      soe_next[1] = 1'b1;
    end else if (sci0_en_in) begin
      so_next[1] = first_serial_transmit_in;
      soe_next[1] = 1'b1;
    end
    if (sci1_en_in | sci0_en_in) begin
      soe_next[0] = 1'b0; // [RULE8]
    end
  end

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port_p_oe_out <= 2'b00;
      port_p_drive_reduce_out <= 2'b00;
      nonmaskable_irq_input_out <= 2'b00;
      serial_pin_out <= 6'b00_0000;
      serial_pin_oe_out <= 6'b00_0000; // [RULE10]
      second_serial_receive_out <= 1'b1;
      first_serial_receive_out <= 1'b1;
      converter_trigger_one_out <= 1'b0;
      converter_trigger_zero_out <= 1'b0;
      spi_pin_rx_out <= 6'b00_0000;
      serial_group_gpio_in_out <= 6'b00_0000;
    end else begin
      port_p_oe_out <= poe_next;
      port_p_drive_reduce_out <= port_p_drive_reduce_reg;
      nonmaskable_irq_input_out <= ppin_s;
      serial_pin_out <= so_next;
      serial_pin_oe_out <= soe_next;
      // Receivers idle high when not routed, so no false start bit appears.
      second_serial_receive_out <= sci1_en_in ? spin_s[0] : 1'b1; // [RULE8]
      first_serial_receive_out <= (~sci1_en_in & sci0_en_in) ? spin_s[0] : 1'b1; // [RULE8]
      converter_trigger_one_out <= (trig1_en_in & ~free_running_clock_out_en_in & ~spi_en_in & ~sci1_en_in & ~pulse_channel_five_en_in)
        ? spin_s[3] : 1'b0; // [RULE5]
      converter_trigger_zero_out <= (trig0_en_in & ~api_clk_en_in & ~spi_en_in & ~sci1_en_in & ~pulse_channel_four_en_in)
        ? spin_s[2] : 1'b0; // [RULE6]
      spi_pin_rx_out <= spi_en_in ? spin_s : 6'b00_0000; // [RULE9]
      serial_group_gpio_in_out <= spin_s;
    end
  end
endmodule // ppr_port_pins

// ---- hdl/ppr_consts.vh ----
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave.
// ----------------------------------------------------------------
`define PPR_OFF_DIR 4'h0
`define PPR_OFF_DRIVE 4'h4
`define PPR_OFF_SGPIO 4'h8
`define PPR_OFF_SDIR 4'hC
`define PPR_ADDR_W 4
// ----------------------------------------------------------------
// Field layouts and reset values.
// ----------------------------------------------------------------
`define PPR_DIR_MASK 8'h03
`define PPR_DRIVE_MASK 8'h06
`define PPR_SGPIO_MASK 8'h3F
`define PPR_RST_8 8'h00
`define PPR_NMI_PIN 1
`define PPR_UNMAPPED_DATA 32'h0000_0000
`endif

// ---- hdl/ppr_sync.v ----
`timescale 1ns/100ps
module ppr_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // Data
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_reg;
  // The first stage is read only by the second stage.
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule // ppr_sync

// ---- verif/ppr_port_pins_assertions.sv ----
`timescale 1ns/100ps
module ppr_port_pins_assertions (
  // Clock, reset and bus
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // Port P
  input wire nmi_mask_in,
  input wire [1:0] pwm_chan_en_in,
  input wire [1:0] port_p_oe_out,
  // Serial group
  input wire free_running_clock_out_en_in,
  input wire api_clk_en_in,
  input wire spi_en_in,
  input wire spi_master_in,
  input wire sci1_en_in,
  input wire free_running_clock_out_in,
  input wire periodic_timer_clock_out_in,
  input wire spi_mosi_in,
  input wire spi_ss_in,
  input wire second_serial_transmit_in,
  input wire [5:0] serial_pin_out,
  input wire [5:0] serial_pin_oe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // ------------------------------------------------------------
  // Lock needs two register stages, so three edges are allowed.
  // ------------------------------------------------------------
  sequence s_unmask;
    $fell(nmi_mask_in);
  endsequence
  sequence s_held_input;
    !port_p_oe_out[1] [*8];
  endsequence
  a_nmi_lock: assert property (s_unmask |-> ##3 s_held_input) else $error("Pin lock lost.");
  a_pwm_forces: assert property (pwm_chan_en_in[0] |=> port_p_oe_out[0]) else $error("Pulse pin.");
  a_drive_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in == 4'h4
    |-> avs_readdata_out[31:3] == 29'h0 && !avs_readdata_out[0]) else $error("Drive bits.");
  a_clk_pin3: assert property (free_running_clock_out_en_in |=> serial_pin_oe_out[3]
    && serial_pin_out[3] == $past(free_running_clock_out_in)) else $error("Pin 3 clock.");
  a_mosi_pin3: assert property (!free_running_clock_out_en_in && spi_en_in && spi_master_in |=> serial_pin_oe_out[3]
    && serial_pin_out[3] == $past(spi_mosi_in)) else $error("Pin 3 data.");
  a_timer_pin2: assert property (api_clk_en_in |=> serial_pin_oe_out[2]
    && serial_pin_out[2] == $past(periodic_timer_clock_out_in)) else $error("Pin 2.");
  a_tx_pin1: assert property (sci1_en_in |=> serial_pin_oe_out[1]
    && serial_pin_out[1] == $past(second_serial_transmit_in)) else $error("Pin 1.");
  a_select_pin5: assert property (spi_en_in && spi_master_in |=> serial_pin_oe_out[5]
    && serial_pin_out[5] == $past(spi_ss_in)) else $error("Pin 5.");
endmodule // ppr_port_pins_assertions

// ---- verif/ppr_pin_model.sv ----
`timescale 1ns/100ps
module ppr_pin_model (
  input wire [5:0] oe_in,
  input wire [5:0] out_in,
  input wire [5:0] ext_in,
  output wire [5:0] pin_out
);
  // A pin the device drives shows its level; otherwise the outside world sets it.
  assign pin_out = (oe_in & out_in) | (~oe_in & ext_in);
endmodule // ppr_pin_model

// ---- verif/ppr_port_pins_tb.sv ----
`timescale 1ns/100ps
module ppr_port_pins_tb;
  logic sys_clk_in, resetn_in, avs_read_in, avs_write_in, nmi_mask_in;
  logic [3:0] avs_address_in, avs_byteenable_in;
  logic [31:0] avs_writedata_in, q;
  logic [1:0] pwm_chan_en_in, port_p_pin_in;
  logic [10:0] en, dat;
  logic [5:0] ext_serial;
  wire avs_waitrequest_out, second_serial_receive_out, first_serial_receive_out;
  wire [31:0] avs_readdata_out;
  wire [1:0] port_p_oe_out, port_p_drive_reduce_out, nonmaskable_irq_input_out;
  wire converter_trigger_one_out, converter_trigger_zero_out;
  wire [5:0] serial_pin_in, serial_pin_out, serial_pin_oe_out, spi_pin_rx_out, serial_group_gpio_in_out;
  int fails = 0, cmp_count = 0, p;
  // Enables from clock out down to phy bit, then drive and level of serial pins 3 to 1.
  logic [16:0] rows [0:8] = '{17'b10000000000_100_100, 17'b10110000000_100_100, 17'b00111000000_101_001,
    17'b00100000000_010_000, 17'b00001011001_101_101, 17'b00000111001_111_010, 17'b00000100110_001_001,
    17'b01000000100_010_010, 17'b00000000000_000_000};
  ppr_port_pins u_dut (.*, .free_running_clock_out_en_in(en[10]), .api_clk_en_in(en[9]), .spi_en_in(en[8]), .spi_master_in(en[7]),
    .sci1_en_in(en[6]), .sci0_en_in(en[5]), .pulse_channel_five_en_in(en[4]), .pulse_channel_four_en_in(en[3]), .trig1_en_in(en[2]),
    .trig0_en_in(en[1]), .phy_en_in(en[0]), .free_running_clock_out_in(dat[10]), .spi_miso_in(dat[7]),
    .periodic_timer_clock_out_in(dat[9]), .spi_mosi_in(dat[8]), .spi_ss_in(dat[6]), .spi_sck_in(dat[5]),
    .second_serial_transmit_in(dat[4]), .first_serial_transmit_in(dat[3]), .pulse_channel_five_in(dat[2]),
    .pulse_channel_four_in(dat[1]), .phy_register_data_bit_in(dat[0]));
  ppr_pin_model u_pins (.oe_in(serial_pin_oe_out), .out_in(serial_pin_out), .ext_in(ext_serial),
    .pin_out(serial_pin_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge sys_clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 20) begin
      fails++;
      $display("Error at %0t: bus wait got %h expected %h", $time, avs_waitrequest_out, 1'b0);
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    {resetn_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, pwm_chan_en_in, port_p_pin_in, en, dat} = '0;
    nmi_mask_in = 1'b1;
    avs_byteenable_in = 4'hF;
    ext_serial = 6'h3F;
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    chk(32'(serial_pin_oe_out), 32'h0);
    chk(32'({serial_pin_out, port_p_oe_out, second_serial_receive_out, first_serial_receive_out}), 32'h3);
    for (p = 0; p < 2; p++) foreach (rows[i]) begin
      en <= rows[i][16:6];
      dat <= p[0] ? ~11'h65A : 11'h65A;
      repeat (3) @(posedge sys_clk_in);
      chk(32'(serial_pin_oe_out[3:1]), 32'(rows[i][5:3]));
      chk(32'(serial_pin_out[3:1] & rows[i][5:3]), 32'((rows[i][2:0] ^ {3{p[0]}}) & rows[i][5:3]));
    end
    en <= 11'h000;
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'hFFFF_FFFF);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h6);
    chk(32'(port_p_drive_reduce_out), 32'h3);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'h0, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    chk(32'(port_p_oe_out), 32'h1);
    pwm_chan_en_in <= 2'b11;
    repeat (2) @(posedge sys_clk_in);
    chk(32'(port_p_oe_out), 32'h3);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1);
    nmi_mask_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    nmi_mask_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk(32'(port_p_oe_out), 32'h1);
    en <= 11'h040;
    ext_serial <= 6'h3E;
    repeat (5) @(posedge sys_clk_in);
    chk(32'({second_serial_receive_out, first_serial_receive_out}), 32'h1);
    en <= 11'h020;
    repeat (5) @(posedge sys_clk_in);
    chk(32'({second_serial_receive_out, first_serial_receive_out}), 32'h2);
    en <= 11'h000;
    ext_serial <= 6'h2D;
    port_p_pin_in <= 2'b10;
    repeat (5) @(posedge sys_clk_in);
    chk(32'(serial_group_gpio_in_out), 32'h2D);
    chk(32'(nonmaskable_irq_input_out), 32'h2);
    en <= 11'h006;
    repeat (3) @(posedge sys_clk_in);
    chk(32'({converter_trigger_one_out, converter_trigger_zero_out}), 32'h3);
    en <= 11'h016;
    repeat (3) @(posedge sys_clk_in);
    chk(32'({converter_trigger_one_out, converter_trigger_zero_out}), 32'h1);
    en <= 11'h180;
    dat <= 11'h020;
    repeat (3) @(posedge sys_clk_in);
    chk(32'({serial_pin_oe_out[5:4], serial_pin_out[5:4]}), 32'hD);
    en <= 11'h100;
    repeat (5) @(posedge sys_clk_in);
    chk(32'({serial_pin_oe_out[5:4], spi_pin_rx_out[5:4]}), 32'h2);
    en <= 11'h000;
    bus(1'b1, 4'hC, 32'h3F);
    bus(1'b1, 4'h8, 32'h15);
    repeat (3) @(posedge sys_clk_in);
    chk(32'({serial_pin_oe_out, serial_pin_out}), 32'hFD5);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h15);
    resetn_in <= 1'b0;
    @(posedge sys_clk_in);
    chk(32'({port_p_oe_out, serial_pin_oe_out}), 32'h0);
    resetn_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    chk(32'({port_p_oe_out, serial_pin_oe_out}), 32'hC0);
    print_verdict();
  end
endmodule // ppr_port_pins_tb
bind ppr_port_pins ppr_port_pins_assertions u_chk (.*);
